// ==== src/adc_ctrl_pkg.sv ====
// Notes on behaviour
// - Power-down bit six powers converter off.
// - Divider select picks conversion clock ratio.
// - Clock register bits five to three read zero.
// - Start low-high-low begins one conversion.
// - Start held high resets converter, busy one.
// - Busy flag clears itself when conversion ends.
// - Conversion end sets request, enabled raises interrupt.
// - Converter runs only with pins and powered.
// - Halt never changes converter power state.
// - No analog pins means all pins digital.
// - Conversion lasts sixteen conversion clock periods.
// - Busy flag bit six, read-only, resets one.
// - Channel select routes one of four inputs.
// - Result high byte, low nibble bits seven-four.
package adc_ctrl_pkg;

  // Register byte addresses.
  localparam logic [7:0] CLK_PWR_OFS = 8'h00;
  localparam logic [7:0] CONV_CTRL_OFS = 8'h04;
  localparam logic [7:0] RES_HI_OFS = 8'h08;
  localparam logic [7:0] RES_LO_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS = 8'h18;

  // Clock and power control fields.
  localparam int TEST_BIT = 7;
  localparam int PDN_BIT = 6;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam logic [7:0] CLK_PWR_RST = 8'h80;
  localparam logic [7:0] CLK_PWR_MASK = 8'hC7;

  // Conversion control fields.
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int PIN_LSB = 2;
  localparam int PIN_W = 4;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 2;

  // Result layout.
  localparam int RES_W = 12;
  localparam int RES_LO_LSB = 4;
  localparam int RES_LO_W = 4;

  // Interrupt status layout.
  localparam int IRQ_W = 1;
  localparam int IRQ_DONE_BIT = 0;

  // Conversion length in conversion clock periods.
  localparam int CONV_PERIODS = 16;
  localparam int CNT_W = 5;

  // Divider select codes.
  localparam logic [2:0] DIV_BY2 = 3'h0;
  localparam logic [2:0] DIV_BY8 = 3'h1;
  localparam logic [2:0] DIV_BY32 = 3'h2;
  localparam logic [2:0] DIV_BY1 = 3'h4;
  localparam logic [2:0] DIV_BY4 = 3'h5;
  localparam logic [2:0] DIV_BY16 = 3'h6;

  typedef struct packed {
    logic power_on;
    logic reset;
    logic start;
    logic [CHAN_W-1:0] channel;
  } conv_ctrl_t;

  // Terminal count (ratio minus one) of the divider for a select code.
  // Undefined codes fall back to the slowest ratio so the engine still ends.
  function automatic logic [CNT_W-1:0] div_limit(input logic [DIV_W-1:0] sel);
    case (sel)
      DIV_BY2: div_limit = 5'h01;
      DIV_BY8: div_limit = 5'h07;
      DIV_BY32: div_limit = 5'h1F;
      DIV_BY1: div_limit = 5'h00;
      DIV_BY4: div_limit = 5'h03;
      DIV_BY16: div_limit = 5'h0F;
      default: div_limit = 5'h1F;
    endcase
  endfunction

endpackage

// ==== src/conv_clock_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module conv_clock_divider
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control
  input wire logic [DIV_W-1:0] div_sel,
  input wire logic run,
  input wire logic restart,
  // Conversion clock period marker
  output logic tick
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] gap_q;

  assign tick = run && (cnt_q == div_limit(div_sel));

  always_ff @(posedge core_clk) begin
    if (srst || !run || restart || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Cycles since the last tick, read only by the checks below.
  always_ff @(posedge core_clk) begin
    if (srst || !run || restart || tick) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 5'h01;
    end
  end

  // Expected ratio as a power of two, kept apart from the divider table so a wrong entry shows.
  function automatic int unsigned ratio_log2(input logic [DIV_W-1:0] sel);
    case (sel)
      DIV_BY1: ratio_log2 = 0;
      DIV_BY2: ratio_log2 = 1;
      DIV_BY4: ratio_log2 = 2;
      DIV_BY8: ratio_log2 = 3;
      DIV_BY16: ratio_log2 = 4;
      default: ratio_log2 = 5;
    endcase
  endfunction

  AST_DIV_PERIOD: assert property (@(posedge core_clk) disable iff (srst)
    tick |-> gap_q == CNT_W'((1 << ratio_log2(div_sel)) - 1)) else $error("Conversion clock period wrong.");

  COV_DIV_ONE: cover property (@(posedge core_clk) disable iff (srst) tick && div_sel == DIV_BY1 ##1 tick);

endmodule
`default_nettype wire

// ==== src/conversion_engine.sv ====
`timescale 1ns/100ps
`default_nettype none
module conversion_engine
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control
  input wire logic power_on,
  input wire logic hold_reset,
  input wire logic start,
  input wire logic tick,
  // Status
  output logic running,
  output logic done
);

  typedef enum logic {ENG_IDLE, ENG_RUN} eng_state_t;

  eng_state_t state_q;
  logic [CNT_W-2:0] periods_q;

  assign running = (state_q == ENG_RUN);
  assign done = running && tick && (periods_q == 4'(CONV_PERIODS - 1));

  always_ff @(posedge core_clk) begin
    if (srst || !power_on || hold_reset) begin
      state_q <= ENG_IDLE;
    end else begin
      case (state_q)
        ENG_IDLE: begin
          if (start) begin
            state_q <= ENG_RUN;
          end
        end
        ENG_RUN: begin
          if (done) begin
            state_q <= ENG_IDLE;
          end
        end
        default: state_q <= ENG_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || state_q != ENG_RUN) begin
      periods_q <= '0;
    end else if (tick) begin
      periods_q <= periods_q + 4'h1;
    end
  end

  AST_SIXTEEN: assert property (@(posedge core_clk) disable iff (srst)
    done |-> $past(running, 1) && periods_q == 4'(CONV_PERIODS - 1)) else $error("Conversion did not last sixteen periods.");

endmodule
`default_nettype wire

// ==== src/adc_control_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
module adc_control_sequencer
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Converter core
  output conv_ctrl_t conv_ctrl,
  output logic conv_tick,
  input wire logic [RES_W-1:0] sar_result,
  // Shared pins
  output logic [PIN_W-1:0] analog_pin_enable,
  output logic [PIN_W-1:0] port_pin_digital,
  // Interrupt
  output logic irq
);

  logic [7:0] clk_pwr_q;
  logic start_bit_q;
  logic start_prev_q;
  logic busy_q;
  logic [PIN_W-1:0] pin_cfg_q;
  logic [CHAN_W-1:0] chan_q;
  logic [RES_W-1:0] res_q;
  logic done_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  conv_ctrl_t conv_ctrl_q;
  logic [PIN_W-1:0] pin_analog_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  logic wr_en;
  logic rd_setup;
  logic start_event;
  logic power_on_d;
  logic tick;
  logic running;
  logic done;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == CLK_PWR_OFS) || (a == CONV_CTRL_OFS) || (a == RES_HI_OFS) ||
                  (a == RES_LO_OFS) || (a == IRQ_STAT_OFS) || (a == IRQ_CLR_OFS) ||
                  (a == IRQ_EN_OFS);
  endfunction

  // The slave answers on the first access cycle; read data is built in setup.
  assign pready = psel && penable;
  assign wr_en = psel && penable && pwrite && pstrb[0] && addr_mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      clk_pwr_q <= CLK_PWR_RST;
    end else if (wr_en && paddr == CLK_PWR_OFS) begin
      clk_pwr_q <= pwdata[7:0] & CLK_PWR_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      start_bit_q <= 1'b0;
      pin_cfg_q <= '0;
      chan_q <= '0;
    end else if (wr_en && paddr == CONV_CTRL_OFS) begin
      start_bit_q <= pwdata[START_BIT];
      pin_cfg_q <= pwdata[PIN_LSB +: PIN_W];
      chan_q <= pwdata[CHAN_LSB +: CHAN_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_bit_q;
    end
  end

  assign start_event = start_prev_q && !start_bit_q;

  // no halt term in power decode
  assign power_on_d = (pin_cfg_q != '0) && !clk_pwr_q[PDN_BIT];

  conv_clock_divider u_div (
    .core_clk(core_clk),
    .srst(srst),
    .div_sel(clk_pwr_q[DIV_LSB +: DIV_W]),
    .run(power_on_d),
    .restart(start_event || start_bit_q),
    .tick(tick)
  );

  conversion_engine u_eng (
    .core_clk(core_clk),
    .srst(srst),
    .power_on(power_on_d),
    .hold_reset(start_bit_q),
    .start(start_event),
    .tick(tick),
    .running(running),
    .done(done)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_q <= 1'b1;
    end else if (start_bit_q) begin
      busy_q <= 1'b1;
    end else if (done_q) begin
      busy_q <= 1'b0;
    end
  end

  // result lands a cycle before busy clears
  always_ff @(posedge core_clk) begin
    if (srst) begin
      res_q <= '0;
    end else if (done) begin
      res_q <= sar_result;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done;
    end
  end

  // A clear that meets a new end in one cycle keeps the bit, so no end is lost.
  // sticky request, set beats clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == IRQ_CLR_OFS) ? pwdata[IRQ_W-1:0] : '0))
                    | IRQ_W'(done_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_en_q <= '0;
    end else if (wr_en && paddr == IRQ_EN_OFS) begin
      irq_en_q <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      conv_ctrl_q <= '0;
    end else begin
      conv_ctrl_q.power_on <= power_on_d;
      conv_ctrl_q.reset <= start_bit_q;
      conv_ctrl_q.start <= start_event && power_on_d;
      conv_ctrl_q.channel <= chan_q;
    end
  end

  assign conv_ctrl = conv_ctrl_q;
  assign conv_tick = tick;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_analog_q <= '0;
    end else begin
      pin_analog_q <= pin_cfg_q;
    end
  end

  assign analog_pin_enable = pin_analog_q;
  assign port_pin_digital = ~pin_analog_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !addr_mapped(paddr);
      prdata_q <= '0;
      if (rd_setup) begin
        case (paddr)
          CLK_PWR_OFS: prdata_q[7:0] <= clk_pwr_q;
          CONV_CTRL_OFS: prdata_q[7:0] <= {start_bit_q, busy_q, pin_cfg_q, chan_q};
          RES_HI_OFS: prdata_q[7:0] <= res_q[RES_W-1 -: 8];
          RES_LO_OFS: prdata_q[RES_LO_LSB +: RES_LO_W] <= res_q[RES_LO_W-1:0];
          IRQ_STAT_OFS: prdata_q[IRQ_W-1:0] <= irq_stat_q;
          IRQ_EN_OFS: prdata_q[IRQ_W-1:0] <= irq_en_q;
          default: prdata_q <= '0;
        endcase
      end
    end
  end

  // Checks.
  AST_POWER_DECODE: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> conv_ctrl_q.power_on == ($past(pin_cfg_q) != '0 && !$past(clk_pwr_q[PDN_BIT])))
    else $error("Converter power does not follow pins and power-down bit.");

  AST_PDN_OFF: assert property (@(posedge core_clk) disable iff (srst)
    clk_pwr_q[PDN_BIT] |=> !conv_ctrl_q.power_on && !running)
    else $error("Converter on while powered down.");

  AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (srst)
    rd_setup && paddr == CLK_PWR_OFS |=> prdata[5:3] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("Unimplemented clock register bits read nonzero.");

  AST_HOLD_RESET: assert property (@(posedge core_clk) disable iff (srst)
    start_bit_q |=> conv_ctrl_q.reset && busy_q && !running)
    else $error("Start high did not hold converter in reset.");

  AST_START_SEQ: assert property (@(posedge core_clk) disable iff (srst)
    start_event && power_on_d && !start_bit_q |=> running && conv_ctrl_q.start)
    else $error("Start sequence did not begin a conversion.");

  // The result must stand before software can see the busy flag fall.
  AST_END_ORDER: assert property (@(posedge core_clk) disable iff (srst)
    done ##1 !start_bit_q |-> res_q == $past(sar_result) && busy_q ##1 (!busy_q || $past(start_bit_q)))
    else $error("Result and busy flag out of order.");

  AST_BUSY_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    done_q && !start_bit_q |=> !busy_q)
    else $error("Busy flag did not clear after conversion.");

  AST_IRQ_SET: assert property (@(posedge core_clk) disable iff (srst)
    done_q |=> irq_stat_q[IRQ_DONE_BIT] ##0 (irq == irq_en_q[IRQ_DONE_BIT]))
    else $error("Conversion end did not raise request.");

  AST_PIN_DIGITAL: assert property (@(posedge core_clk) disable iff (srst)
    pin_cfg_q == '0 ##1 pin_cfg_q == '0 |-> port_pin_digital == 4'hF && analog_pin_enable == 4'h0)
    else $error("Pins not digital with no analog configuration.");

  AST_CHANNEL: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> conv_ctrl_q.channel == $past(chan_q))
    else $error("Channel select not routed.");

  AST_RESULT_LAYOUT: assert property (@(posedge core_clk) disable iff (srst)
    rd_setup && paddr == RES_LO_OFS |=> prdata[3:0] == 4'h0 && prdata[7:4] == $past(res_q[RES_LO_W-1:0]))
    else $error("Low result layout wrong.");

  AST_BUSY_RESET: assert property (@(posedge core_clk)
    $past(srst) |-> busy_q)
    else $error("Busy flag not one after reset.");

  AST_IRQ_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    wr_en && paddr == IRQ_CLR_OFS && pwdata[IRQ_DONE_BIT] && !done_q |=> !irq_stat_q[IRQ_DONE_BIT])
    else $error("Interrupt request did not clear.");

  AST_UNPOWERED_START: assert property (@(posedge core_clk) disable iff (srst)
    start_event && !power_on_d |=> !running && busy_q)
    else $error("Conversion began without converter power.");

  AST_BUSY_FALL: assert property (@(posedge core_clk) disable iff (srst)
    $fell(busy_q) |-> $past(done_q))
    else $error("Busy flag fell without a finished conversion.");

  AST_BUSY_RUNNING: assert property (@(posedge core_clk) disable iff (srst)
    running |-> busy_q)
    else $error("Busy flag low during a conversion.");

  AST_PIN_ANALOG: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> analog_pin_enable == $past(pin_cfg_q) && port_pin_digital == ~$past(pin_cfg_q))
    else $error("Pin function does not follow pin configuration.");

  AST_RESULT_HIGH: assert property (@(posedge core_clk) disable iff (srst)
    rd_setup && paddr == RES_HI_OFS |=> prdata[7:0] == $past(res_q[RES_W-1 -: 8]) && prdata[31:8] == 24'h0)
    else $error("High result layout wrong.");

  COV_CONVERSION: cover property (@(posedge core_clk) disable iff (srst) start_event ##1 running ##[1:600] done);
  COV_UNPOWERED: cover property (@(posedge core_clk) disable iff (srst) start_event && !power_on_d);
  COV_IRQ: cover property (@(posedge core_clk) disable iff (srst) done_q ##1 irq);
  COV_ABORT: cover property (@(posedge core_clk) disable iff (srst) running ##1 start_bit_q);

endmodule
`default_nettype wire

// ==== test/sar_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sar_model
  import adc_ctrl_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Control from the sequencer
  input wire conv_ctrl_t conv_ctrl,
  input wire logic conv_tick,
  // Result
  output logic [RES_W-1:0] sar_result
);
  logic [4:0] steps_q;
  logic [RES_W-1:0] settled;
  always_ff @(posedge core_clk) begin
    if (conv_ctrl.reset || conv_ctrl.start) begin
      steps_q <= 5'h00;
    end else if (conv_tick && steps_q != 5'h1F) begin
      steps_q <= steps_q + 5'h01;
    end
  end
  assign settled = {conv_ctrl.channel, 10'h2A5};
  // The inverse shows until late in the cycle, so an early capture is caught.
  assign sar_result = (conv_ctrl.power_on && !conv_ctrl.reset && steps_q >= 5'h0A) ? settled : ~settled;
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import adc_ctrl_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic e;} row_t;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, conv_tick, irq, irq_prev, last_tick, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, analog_pin_enable, port_pin_digital;
  logic [RES_W-1:0] sar_result, val;
  logic [1:0] ch;
  conv_ctrl_t conv_ctrl;
  int fail_count, tests_run, tick_cnt, since, gap, done_ticks;
  row_t rows [7];
  logic [2:0] codes [6];
  int ratios [6];

  adc_control_sequencer dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .conv_ctrl(conv_ctrl), .conv_tick(conv_tick), .sar_result(sar_result),
    .analog_pin_enable(analog_pin_enable), .port_pin_digital(port_pin_digital), .irq(irq));
  sar_model far_end (.core_clk(core_clk), .conv_ctrl(conv_ctrl), .conv_tick(conv_tick), .sar_result(sar_result));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // A tick in the cycle after the last one is dropped, in case the divider runs on.
  always @(posedge core_clk) begin
    irq_prev <= irq;
    last_tick <= conv_tick;
    if (irq && !irq_prev) done_ticks <= tick_cnt - int'(last_tick);
    if (conv_ctrl.start) tick_cnt <= conv_tick ? 1 : 0;
    else if (conv_tick) tick_cnt <= tick_cnt + 1;
    if (conv_tick) begin
      gap <= since;
      since <= 1;
    end else since <= since + 1;
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      tally_and_finish();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    `CHK(nm, e, rd[7:0])
  endtask

  task automatic setup_pwr(input logic pdn, input logic [3:0] pins, input logic [2:0] code, input logic [1:0] c);
    apb(1'b1, CLK_PWR_OFS, {1'b1, pdn, 3'b000, code});
    apb(1'b1, CONV_CTRL_OFS, {2'b00, pins, c});
    repeat (3) @(posedge core_clk);
  endtask

  task automatic pulse_start(input logic [3:0] pins, input logic [1:0] c);
    apb(1'b1, CONV_CTRL_OFS, {2'b10, pins, c});
    repeat (2) @(posedge core_clk);
    `CHK("conv_reset", 1'b1, conv_ctrl.reset)
    rdchk(CONV_CTRL_OFS, {2'b11, pins, c}, "busy_in_reset");
    apb(1'b1, CONV_CTRL_OFS, {2'b00, pins, c});
  endtask

  task automatic wait_busy_low;
    int n;
    n = 0;
    do begin
      apb(1'b0, CONV_CTRL_OFS, 8'h00);
      n++;
    end while (rd[BUSY_BIT] !== 1'b0 && n < 400);
    if (n >= 400) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    fail_count = 0;
    tests_run = 0;
    tick_cnt = 0;
    since = 0;
    gap = 0;
    done_ticks = 0;
    irq_prev = 1'b0;
    last_tick = 1'b0;
    rows = '{'{8'h00, 8'hFE, 8'hC6, 1'b0}, '{8'h00, 8'hB8, 8'h80, 1'b0}, '{8'h00, 8'hC5, 8'hC5, 1'b0},
      '{8'h04, 8'h3E, 8'h7E, 1'b0}, '{8'h1C, 8'h55, 8'h00, 1'b1}, '{8'h14, 8'h01, 8'h00, 1'b0},
      '{8'h18, 8'h01, 8'h01, 1'b0}};
    codes = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2};
    ratios = '{1, 2, 4, 8, 16, 32};
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rdchk(CLK_PWR_OFS, 8'h80, "clk_pwr_reset");
    rdchk(CONV_CTRL_OFS, 8'h40, "ctrl_reset");
    `CHK("digital_reset", 4'hF, port_pin_digital)
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 8'h00);
      `CHK("row_data", rows[i].r, rd[7:0])
      `CHK("row_err", rows[i].e, err)
    end
    setup_pwr(1'b0, 4'h0, 3'h0, 2'h0);
    `CHK("power_no_pins", 1'b0, conv_ctrl.power_on)
    `CHK("digital_all", 4'hF, port_pin_digital)
    setup_pwr(1'b1, 4'hA, 3'h0, 2'h0);
    `CHK("power_down", 1'b0, conv_ctrl.power_on)
    `CHK("analog_pins", 4'hA, analog_pin_enable)
    setup_pwr(1'b0, 4'h5, 3'h0, 2'h0);
    `CHK("power_up", 1'b1, conv_ctrl.power_on)
    `CHK("digital_some", 4'hA, port_pin_digital)
    apb(1'b1, IRQ_EN_OFS, 8'h01);
    for (int i = 0; i < 6; i++) begin
      ch = i[1:0];
      val = {ch, 10'h2A5};
      setup_pwr(1'b0, 4'h1, codes[i], ch);
      pulse_start(4'h1, ch);
      wait_busy_low();
      `CHK("tick_count", 16, done_ticks)
      `CHK("tick_gap", ratios[i], gap)
      rdchk(RES_HI_OFS, val[11:4], "result_high");
      rdchk(RES_LO_OFS, {val[3:0], 4'h0}, "result_low");
      rdchk(IRQ_STAT_OFS, 8'h01, "irq_status");
      `CHK("irq_on", 1'b1, irq)
      apb(1'b1, IRQ_CLR_OFS, 8'h01);
      rdchk(IRQ_STAT_OFS, 8'h00, "irq_cleared");
      `CHK("irq_off", 1'b0, irq)
    end
    apb(1'b1, IRQ_EN_OFS, 8'h00);
    setup_pwr(1'b0, 4'h8, 3'h4, 2'h3);
    pulse_start(4'h8, 2'h3);
    wait_busy_low();
    rdchk(IRQ_STAT_OFS, 8'h01, "masked_status");
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, IRQ_EN_OFS, 8'h01);
    rdchk(IRQ_EN_OFS, 8'h01, "irq_enable");
    `CHK("irq_unmasked", 1'b1, irq)
    apb(1'b1, IRQ_CLR_OFS, 8'h01);
    setup_pwr(1'b1, 4'h8, 3'h4, 2'h3);
    pulse_start(4'h8, 2'h3);
    repeat (100) @(posedge core_clk);
    rdchk(CONV_CTRL_OFS, 8'h63, "busy_unpowered");
    tally_and_finish();
  end
endmodule
`default_nettype wire
